//--- sfwdg_top.sv
// Purpose: Software fault watchdog with one control register on Avalon-MM
// Assumes: All inputs synchronous to i_sys_clk; i_hw_opt static
// Notes: o_chip_rst_n is a request to the chip reset logic, which is
//        expected to assert i_rst back to this block

`timescale 1ns/1ps

module sfwdg_top
#(
  parameter int unsigned PRESC_CYC = sfwdg_pkg::PRESC_CYC_DEF
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire sfwdg_pkg::sfwdg_avs_req_t i_avs,
  input wire logic i_hw_opt,
  input wire logic i_halt,
  input wire logic i_ext_wake,
  output logic [sfwdg_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_chip_rst_n,
  output logic o_active,
  output logic o_frozen
);
  import sfwdg_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  generate
    if (PRESC_CYC < 2 || PRESC_CYC > (1 << 24))
    begin : g_bad_presc
      $error("PRESC_CYC out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic active_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic hw_mode_r;
  logic strap_done_r;
  logic [2:0] pulse_r;
  logic [2:0] pulse_nxt;
  logic rst_n_r;
  logic [9:0] restart_r;
  logic [9:0] restart_nxt;
  sfwdg_state_t state_r;
  sfwdg_state_t state_nxt;
  logic active_out_r;
  logic frozen_out_r;

  logic req_w;
  logic hit_w;
  logic take_w;
  logic ack_w;
  logic wr_en_w;
  logic rd_take_w;
  sfwdg_ctrl_t wr_ctrl_w;
  sfwdg_ctrl_t rd_ctrl_w;
  logic run_w;
  logic tick_w;
  logic dec_w;
  logic eff_active_w;
  logic timeout_w;
  logic swrst_w;
  logic fire_w;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One wait state: request seen while wait_r is high, answered next edge
  assign req_w = i_avs.read | i_avs.write;
  assign hit_w = i_avs.address == CTRL_ADDR;
  assign take_w = req_w & wait_r;
  assign ack_w = req_w & ~wait_r;
  assign wr_en_w = ack_w & i_avs.write & hit_w;
  assign rd_take_w = take_w & i_avs.read & hit_w;
  assign wr_ctrl_w = sfwdg_ctrl_t'(i_avs.writedata[7:0]);
  // Bit 7 shows the activate flag, bits 6:0 the live count
  assign rd_ctrl_w = '{activate: active_r, count: cnt_r};
  // Unmapped reads answer zero
  assign rdata_nxt = rd_take_w ? DATA_W'(rd_ctrl_w) :
                     (take_w ? '0 : rdata_r);

  // ---------------------------------------------------------------
  // Option strap
  // ---------------------------------------------------------------
  // Captured by the first clock after reset release, never by the reset
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_done_r <= 1'b0;
      hw_mode_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      hw_mode_r <= i_hw_opt;
    end
  end

  // ---------------------------------------------------------------
  // Low power sequencing
  // ---------------------------------------------------------------
  // Wait mode has no input here: counting never looks at it
  always_comb
  begin
    state_nxt = state_r;
    restart_nxt = restart_r;
    unique case (state_r)
      ST_RUN:
      begin
        if (i_halt)
        begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT:
      begin
        if (i_ext_wake)
        begin
          state_nxt = ST_WAKE;
          restart_nxt = WAKE_LOAD;
        end
      end
      ST_WAKE:
      begin
        if (restart_r == '0)
        begin
          state_nxt = ST_RUN;
        end
        else
        begin
          restart_nxt = 10'(restart_r - 1'b1);
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
        restart_nxt = '0;
      end
    endcase
  end

  assign run_w = state_r == ST_RUN;

  sfwdg_prescaler
  #(
    .DIV(PRESC_CYC)
  )
  u_presc
  (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(run_w),
    .o_tick(tick_w)
  );

  // ---------------------------------------------------------------
  // Countdown and reset decision
  // ---------------------------------------------------------------
  // A refresh in the tick cycle wins; the step is lost, not the write
  assign dec_w = tick_w & run_w & ~wr_en_w;
  assign eff_active_w = hw_mode_r | active_r;
  assign timeout_w = eff_active_w & dec_w & (cnt_r == CNT_TRIP);
  // Activate bit written as zero still fires if already active
  assign swrst_w = wr_en_w & (wr_ctrl_w.activate | eff_active_w) &
                   ~wr_ctrl_w.count[TOP_BIT];
  assign fire_w = timeout_w | swrst_w;
  assign cnt_nxt = wr_en_w ? wr_ctrl_w.count :
                   (dec_w ? CNT_W'(cnt_r - CNT_ONE) : cnt_r);
  assign pulse_nxt = fire_w ? PULSE_LOAD :
                     ((pulse_r != '0) ? 3'(pulse_r - 1'b1) : pulse_r);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= CNT_RST;
      active_r <= CTRL_ACT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      // Only a set path exists; reset is the sole clear
      active_r <= active_r | (wr_en_w & wr_ctrl_w.activate);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pulse_r <= '0;
      rst_n_r <= 1'b1;
      state_r <= ST_RUN;
      restart_r <= '0;
    end
    else
    begin
      pulse_r <= pulse_nxt;
      rst_n_r <= pulse_nxt == '0;
      state_r <= state_nxt;
      restart_r <= restart_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      active_out_r <= 1'b0;
      frozen_out_r <= 1'b0;
    end
    else
    begin
      wait_r <= ~take_w;
      rdata_r <= rdata_nxt;
      active_out_r <= eff_active_w;
      frozen_out_r <= ~run_w;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_chip_rst_n = rst_n_r;
  assign o_active = active_out_r;
  assign o_frozen = frozen_out_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_fire;
    fire_w;
  endsequence

  sequence s_low_pulse;
    !o_chip_rst_n [*5] ##1 o_chip_rst_n;
  endsequence

  sequence s_wake;
    state_r == ST_HALT && i_ext_wake;
  endsequence

  step_down_a: assert property (
    dec_w |=> cnt_r == CNT_W'($past(cnt_r) - CNT_ONE))
    else $error("countdown did not step by one");

  // A refire restarts the pulse, so the check is on its end, not its start
  trip_pulse_a: assert property (
    s_fire ##1 !fire_w [*5] |-> ($past(!o_chip_rst_n, 4) && !o_chip_rst_n) ##1 o_chip_rst_n)
    else $error("reset pulse shape wrong");

  timeout_reset_a: assert property (
    (timeout_w && !$past(fire_w)) |=> s_low_pulse or (!o_chip_rst_n ##1 fire_w))
    else $error("timeout did not pull reset low");

  idle_safe_a: assert property (
    (!hw_mode_r && !active_r && dec_w && cnt_r == CNT_TRIP) |=> o_chip_rst_n)
    else $error("inactive watchdog caused reset");

  soft_reset_a: assert property (
    (wr_en_w && wr_ctrl_w.activate && !wr_ctrl_w.count[TOP_BIT]) |=> !o_chip_rst_n)
    else $error("forced reset write ignored");

  hw_active_a: assert property (
    (strap_done_r && hw_mode_r) |=> o_active)
    else $error("hardware option not active");

  halt_freeze_a: assert property (
    (state_r != ST_RUN && !wr_en_w) |=> $stable(cnt_r) && !$rose(fire_w))
    else $error("count moved while frozen");

  wake_delay_a: assert property (
    s_wake |=> state_r == ST_WAKE && restart_r == WAKE_LOAD)
    else $error("wake delay not loaded");

  wake_resume_a: assert property (
    (state_r == ST_WAKE && restart_r == '0) |=> state_r == ST_RUN ##1 !o_frozen)
    else $error("wake delay did not end");

  activate_sticky_a: assert property (
    active_r |=> active_r)
    else $error("activate flag cleared by write");

  read_value_a: assert property (
    (rd_take_w && !wr_en_w) |=> o_avs_readdata == DATA_W'({$past(active_r), $past(cnt_r)}))
    else $error("read data does not match register");

  bus_answer_a: assert property (
    take_w |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest did not answer in one cycle");

endmodule

//--- sfwdg_pkg.sv
// Purpose: Shared constants and carriers of the software fault watchdog
// Assumes: 10 MHz system clock, 32-bit Avalon-MM register bus
// Notes: Every offset, reset value, field position and timing count lives here

package sfwdg_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // Control register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_IDX = 8'h0D;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'h0};
  localparam int unsigned CNT_W = 7;
  localparam int unsigned ACT_BIT = 7;
  localparam int unsigned TOP_BIT = 6;
  localparam logic [7:0] CTRL_RST = 8'h7F;
  localparam logic [CNT_W-1:0] CNT_RST = CTRL_RST[CNT_W-1:0];
  localparam logic CTRL_ACT_RST = CTRL_RST[ACT_BIT];
  localparam logic [CNT_W-1:0] CNT_TRIP = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RST_PULSE_NS = 500;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PULSE_LOAD = 3'(RST_PULSE_CYC);
  localparam int unsigned WAKE_DELAY_CLK = 514;
  localparam logic [9:0] WAKE_LOAD = 10'(WAKE_DELAY_CLK - 1);
  localparam int unsigned PRESC_CYC_DEF = 65536;

  // ---------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } sfwdg_avs_req_t;

  typedef struct packed {
    logic activate;
    logic [CNT_W-1:0] count;
  } sfwdg_ctrl_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_HALT = 3'h2,
    ST_WAKE = 3'h4
  } sfwdg_state_t;

endpackage

//--- sfwdg_prescaler.sv
// Purpose: Step divider that paces the watchdog countdown
// Assumes: i_run low freezes the divider where it stands
// Notes: Tick is a one-cycle pulse from a flip-flop

`timescale 1ns/1ps

module sfwdg_prescaler
#(
  parameter int unsigned DIV = sfwdg_pkg::PRESC_CYC_DEF
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_tick
);
  import sfwdg_pkg::*;

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_r;
  logic [W-1:0] div_nxt;
  logic wrap_w;
  logic tick_r;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  assign wrap_w = i_run & (div_r == LAST);
  assign div_nxt = !i_run ? div_r : (wrap_w ? '0 : W'(div_r + 1'b1));

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= wrap_w;
    end
  end

  assign o_tick = tick_r;

endmodule

//--- sfwdg_top_bench.sv
// Purpose: Self-checking bench of the software fault watchdog
// Assumes: PRESC_CYC shortened to 16, so one count step is 16 clocks
// Notes: Bench plays the chip reset logic and re-asserts reset after each pulse

`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module sfwdg_top_bench;
  import sfwdg_pkg::*;
  localparam int unsigned STEP = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  sfwdg_avs_req_t avs = '0;
  logic hw_opt = 1'b0;
  logic halt = 1'b0;
  logic ext_wake = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic wait_req, chip_rst_n, active, frozen;
  logic [31:0] seed = 32'h79BC;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  sfwdg_top #(.PRESC_CYC(STEP)) i_sfwdg_top (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_avs(avs), .i_hw_opt(hw_opt),
    .i_halt(halt), .i_ext_wake(ext_wake), .o_avs_readdata(rd_data),
    .o_avs_waitrequest(wait_req), .o_chip_rst_n(chip_rst_n),
    .o_active(active), .o_frozen(frozen));

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a,
                                               input logic [7:0] v);
    return (a == CTRL_ADDR) ? DATA_W'(v) : '0;
  endfunction

  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic opt);
    hw_opt <= opt;
    halt <= 1'b0;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [DATA_W-1:0] q);
    int n;
    @(posedge sys_clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: DATA_W'(d)};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 20);
    q = rd_data;
    avs <= '0;
    `CHK("bus_answer", 1'b1, n < 20)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [DATA_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] v);
    logic [DATA_W-1:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK("read_data", exp_rd(a, v), q)
  endtask

  task automatic wait_low(input int maxw, output int n);
    n = 0;
    while (chip_rst_n !== 1'b0 && n < maxw)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic pulse_chk(input int minw, input int maxw);
    int n, w;
    wait_low(maxw, n);
    `CHK("pulse_start_ok", 1'b1, n >= minw && n < maxw)
    w = 0;
    while (chip_rst_n === 1'b0 && w < 20)
    begin
      @(posedge sys_clk);
      w++;
    end
    `CHK("pulse_len", RST_PULSE_CYC, w)
    // Spare edge so the pulse end is seen before reset is applied again
    @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [DATA_W-1:0] q1, q2;
    logic [31:0] r;
    logic [7:0] v, a;
    int n, t0;
    do_reset(1'b0);
    rd_chk(CTRL_ADDR, 8'h7F);
    `CHK("active_after_rst", 1'b0, active)
    // Reads 64 clocks apart must see exactly four steps
    bus(1'b0, CTRL_ADDR, 8'h00, q1);
    repeat (4 * STEP - 3) @(posedge sys_clk);
    bus(1'b0, CTRL_ADDR, 8'h00, q2);
    `CHK("step_rate", 7'(q1[6:0] - 7'h04), q2[6:0])
    // Strap moved after sampling; count passes 40h with no reset
    hw_opt <= 1'b1;
    wait_low(1100, n);
    `CHK("no_fire_inactive", 1100, n)
    `CHK("strap_static", 1'b0, active)
    hw_opt <= 1'b0;
    wr(CTRL_ADDR, 8'hFF);
    repeat (12)
    begin
      r = xs();
      v = 8'hC2 + 8'(r[15:0] % 62);
      wr(CTRL_ADDR, v);
      bus(1'b0, CTRL_ADDR, 8'h00, q1);
      `CHK("refresh_read", 1'b1, q1[7:0] === v || q1[7:0] === v - 8'h01)
      a = r[23:16];
      if (a == CTRL_ADDR)
        a = a ^ 8'h04;
      wr(a, 8'h80);
      rd_chk(a, 8'h00);
      `CHK("no_fire_refreshed", 1'b1, chip_rst_n)
    end
    // Write of activate zero must not switch the watchdog off
    wr(CTRL_ADDR, 8'h41);
    bus(1'b0, CTRL_ADDR, 8'h00, q1);
    `CHK("activate_sticky", 1'b1, q1[7])
    pulse_chk(8, 2 * STEP + 8);
    do_reset(1'b0);
    r = xs();
    wr(CTRL_ADDR, 8'h80 | (r[7:0] & 8'h3F));
    pulse_chk(0, 4);
    do_reset(1'b0);
    // Halt freezes, wake waits before counting again
    wr(CTRL_ADDR, 8'hFF);
    halt <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("frozen_in_halt", 1'b1, frozen)
    bus(1'b0, CTRL_ADDR, 8'h00, q1);
    repeat (200) @(posedge sys_clk);
    bus(1'b0, CTRL_ADDR, 8'h00, q2);
    `CHK("halt_count_held", q1, q2)
    `CHK("no_fire_in_halt", 1'b1, chip_rst_n)
    t0 = cyc;
    ext_wake <= 1'b1;
    halt <= 1'b0;
    @(posedge sys_clk);
    ext_wake <= 1'b0;
    bus(1'b0, CTRL_ADDR, 8'h00, q1);
    repeat (4 * STEP - 3) @(posedge sys_clk);
    bus(1'b0, CTRL_ADDR, 8'h00, q2);
    `CHK("wake_count_held", q1, q2)
    n = 0;
    while (frozen !== 1'b0 && n < 600)
    begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("wake_delay", 1'b1, cyc - t0 >= 512 && cyc - t0 <= 518)
    bus(1'b0, CTRL_ADDR, 8'h00, q1);
    repeat (4 * STEP - 3) @(posedge sys_clk);
    bus(1'b0, CTRL_ADDR, 8'h00, q2);
    `CHK("wake_resumed", 7'(q1[6:0] - 7'h04), q2[6:0])
    // Reset that ends halt leaves the watchdog inactive
    halt <= 1'b1;
    repeat (3) @(posedge sys_clk);
    do_reset(1'b0);
    // Past the reset values: flags now come from live state
    repeat (3) @(posedge sys_clk);
    `CHK("halt_rst_active", 1'b0, active)
    `CHK("halt_rst_frozen", 1'b0, frozen)
    rd_chk(CTRL_ADDR, 8'h7F);
    // Always-active option ignores the activate bit
    do_reset(1'b1);
    repeat (3) @(posedge sys_clk);
    `CHK("hw_active", 1'b1, active)
    rd_chk(CTRL_ADDR, 8'h7F);
    wr(CTRL_ADDR, 8'h41);
    pulse_chk(8, 2 * STEP + 8);
    do_reset(1'b0);
    final_report();
  end

  // ---------------------------------------------------------------
  // Watchdog of the bench
  // ---------------------------------------------------------------
  initial
  begin
    #3_000_000;
    err_total++;
    final_report();
  end
endmodule
